// ---- rtl/sedf_top.sv ----
/*
 * Sense error detail formatter: builds sense bytes 20 to 31 from an error
 * record captured in the drive controller clock domain, holds them for the
 * request-sense transfer and shows them to software over AHB-Lite.
 * Assumes record inputs come from logic on hclk and are valid while
 * rec_capture is high; the sense byte port is read by same-clock logic.
 */
// The register offsets and the AHB-Lite register port were left to the implementer.
//
// Function
// - Read/write error puts disk controller status and error snapshots in bytes 20-23.
// - Byte 23 flags overrun, write abort, write fault, address mark mismatch, request error.
// - Byte 23 bit 1 flags an eleven-byte thermal asperity.
// - Byte 23 bit 0 is one-byte asperity on reads, channel fault on writes.
// - An alert reported with code 5Dh puts a reason code in byte 21.
// - Reason codes 32h, 4Ah, 43h for read, write and seek error rates.
// - Reason codes 14h spare sectors, 56h spin-up time, 5Bh spin-up retries.
// - Reason codes 00h power-on hours, 50h load/unload cycles.
// - With incorrect length flagged, bytes 24 to 29 are zero.
// - Otherwise cylinder in 24-25, head in 26, sector in 28-29.
// - Byte 27 holds sector 0 to 254, else 0FFh.
// - Unknown head reads as 0FFh.
// - Unknown cylinder reads as 0FFFh in bytes 24-25.
// - Unknown sector sets bytes 27, 28 and 29 to 0FFh.
// - Location irrelevant to the error sets bytes 24 to 29 to 0FFh.
// - Location record is meaningful only for sense keys 1, 3 and 4.
// - Bytes 30 and 31 are reserved and read as zero.
`timescale 1ns/1ns
`default_nettype none

module sedf_top (
	input  wire logic        hclk,            // Bus and controller clock.
	input  wire logic        hresetn,         // Asynchronous reset, active low.
	input  wire logic        hsel,            // Slave select.
	input  wire logic [31:0] haddr,           // Byte address.
	input  wire logic [1:0]  htrans,          // Transfer type.
	input  wire logic        hwrite,          // Write when high.
	input  wire logic [2:0]  hsize,           // Transfer size.
	input  wire logic        hready,          // Bus ready in.
	input  wire logic [31:0] hwdata,          // Write data.
	output logic      [31:0] hrdata,          // Read data.
	output logic             hreadyout,       // Slave ready.
	output logic             hresp,           // Response, always OKAY.
	output logic             irq,             // Level interrupt.
	input  wire logic        rec_capture,     // Pulse: record inputs valid.
	input  wire logic [1:0]  rec_kind,        // Kind of error event.
	input  wire logic        rec_is_write,    // Failed operation was a write.
	input  wire logic [3:0]  rec_sense_key,   // Sense key of the report.
	input  wire logic [7:0]  rec_asc,         // Additional sense code.
	input  wire logic [23:0] dc_snapshot,     // Disk controller status, bytes 20-22.
	input  wire logic        err_overrun,     // Data overrun.
	input  wire logic        err_write_abort, // Write aborted.
	input  wire logic        err_write_fault, // Write fault.
	input  wire logic        err_data_address_mark, // Address mark mismatch.
	input  wire logic        err_req,         // Request handshake error.
	input  wire logic        err_ta_long,     // Eleven-byte thermal asperity.
	input  wire logic        err_bit0,        // Short asperity or channel fault.
	input  wire logic [2:0]  alert_reason,    // Alert reason select.
	input  wire logic        incorrect_length_flag, // Incorrect length indicator.
	input  wire logic        loc_relevant,    // Location bears on the error.
	input  wire logic        cyl_known,       // Cylinder determined.
	input  wire logic [15:0] cyl,             // Cylinder number.
	input  wire logic        head_known,      // Head determined.
	input  wire logic [7:0]  head,            // Head number.
	input  wire logic        sec_known,       // Sector determined.
	input  wire logic [15:0] sec,             // Sector number.
	input  wire logic [3:0]  tail_sel,        // Tail byte index, 0 is byte 20.
	output logic      [7:0]  tail_byte,       // Selected sense byte.
	output logic             rec_valid        // Location record meaningful.
);
	localparam logic [7:0] ALERT_ASC = 8'h5d;

	function automatic logic [7:0] reason_code(input logic [2:0] r);
		unique case (sedf_pkg::sedf_reason_t'(r))
			sedf_pkg::SEDF_RSN_READ_RATE:    reason_code = sedf_pkg::CODE_READ_RATE;
			sedf_pkg::SEDF_RSN_WRITE_RATE:   reason_code = sedf_pkg::CODE_WRITE_RATE;
			sedf_pkg::SEDF_RSN_SEEK_RATE:    reason_code = sedf_pkg::CODE_SEEK_RATE;
			sedf_pkg::SEDF_RSN_SPARE:        reason_code = sedf_pkg::CODE_SPARE;
			sedf_pkg::SEDF_RSN_SPINUP_TIME:  reason_code = sedf_pkg::CODE_SPINUP_TIME;
			sedf_pkg::SEDF_RSN_SPINUP_RETRY: reason_code = sedf_pkg::CODE_SPINUP_RETRY;
			sedf_pkg::SEDF_RSN_POWER_HOURS:  reason_code = sedf_pkg::CODE_POWER_HOURS;
			sedf_pkg::SEDF_RSN_LOAD_CYCLES:  reason_code = sedf_pkg::CODE_LOAD_CYCLES;
		endcase
	endfunction

	function automatic logic key_meaningful(input logic [3:0] k);
		key_meaningful = (k == sedf_pkg::KEY_RECOVERED) || (k == sedf_pkg::KEY_MEDIUM)
			|| (k == sedf_pkg::KEY_HARDWARE);
	endfunction

	// The tail index port is four bits wide and the reserved pair must close the tail.
	if (sedf_pkg::TAIL_LEN > 16 || sedf_pkg::IDX_RSV1 != sedf_pkg::TAIL_LEN - 1) begin : g_bad_tail
		$error("tail geometry does not fit the index port");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave.

	logic                 ctrl_en_q;
	logic [1:0]           irq_stat_q;
	logic [1:0]           irq_mask_q;
	logic [7:0]           tail_q [sedf_pkg::TAIL_LEN];
	logic [7:0]           tail_d [sedf_pkg::TAIL_LEN];
	logic                 rec_valid_q;
	logic [3:0]           key_q;
	logic                 dir_q;
	logic                 wr_pend_q;
	logic [7:0]           wr_addr_q;
	logic [31:0]          rdata_q;
	logic [31:0]          rdata_d;
	logic                 addr_take;
	logic                 take;
	logic [1:0]           stat_clr;
	logic [1:0]           stat_set;

	assign addr_take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	// Read data is latched in the address phase, so every access takes no wait state.
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (haddr[7:0])
			sedf_pkg::ADDR_CTRL:     rdata_d[sedf_pkg::CTRL_EN_BIT] = ctrl_en_q;
			sedf_pkg::ADDR_IRQ_STAT: rdata_d[1:0] = irq_stat_q;
			sedf_pkg::ADDR_IRQ_MASK: rdata_d[1:0] = irq_mask_q;
			sedf_pkg::ADDR_TAIL_A:   rdata_d = {tail_q[3], tail_q[2], tail_q[1], tail_q[0]};
			sedf_pkg::ADDR_TAIL_B:   rdata_d = {tail_q[7], tail_q[6], tail_q[5], tail_q[4]};
			sedf_pkg::ADDR_TAIL_C:   rdata_d = {tail_q[11], tail_q[10], tail_q[9], tail_q[8]};
			sedf_pkg::ADDR_INFO:     rdata_d[5:0] = {dir_q, rec_valid_q, key_q};
			default:                 rdata_d = 32'h0000_0000;
		endcase
		if (haddr[31:8] != 24'h00_0000) begin
			rdata_d = 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q   <= 32'h0000_0000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_take && hwrite && (haddr[31:8] == 24'h00_0000);
			if (addr_take) begin
				wr_addr_q <= haddr[7:0];
				if (!hwrite) begin
					rdata_q <= rdata_d;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_en_q  <= sedf_pkg::CTRL_EN_RST;
			irq_mask_q <= sedf_pkg::IRQ_MASK_RST;
		end else if (wr_pend_q) begin
			if (wr_addr_q == sedf_pkg::ADDR_CTRL) begin
				ctrl_en_q <= hwdata[sedf_pkg::CTRL_EN_BIT];
			end
			if (wr_addr_q == sedf_pkg::ADDR_IRQ_MASK) begin
				irq_mask_q <= hwdata[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts: a new event wins over a write-one-to-clear in the same cycle.

	assign take     = rec_capture && ctrl_en_q;
	assign stat_clr = (wr_pend_q && wr_addr_q == sedf_pkg::ADDR_IRQ_STAT) ? hwdata[1:0] : 2'h0;
	assign stat_set = {take && rec_kind == sedf_pkg::SEDF_KIND_ALERT && rec_asc == ALERT_ASC,
		take};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= 2'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~stat_clr) | stat_set;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	////////////////////////////////////////////////////////////////////////////////
	// Formatter.

	always_comb begin
		for (int i = 0; i < sedf_pkg::TAIL_LEN; i++) begin
			tail_d[i] = 8'h00;
		end
		if (rec_kind == sedf_pkg::SEDF_KIND_RW) begin
			{tail_d[2], tail_d[1], tail_d[0]} = dc_snapshot;
			tail_d[sedf_pkg::IDX_VU3] = {err_overrun, err_write_abort, err_write_fault,
				err_data_address_mark, 1'b0, err_req, err_ta_long, err_bit0};
		end else if (rec_kind == sedf_pkg::SEDF_KIND_ALERT && rec_asc == ALERT_ASC) begin
			tail_d[sedf_pkg::IDX_VU1] = reason_code(alert_reason);
		end
		// The incorrect length case is checked first: it zeroes the whole record.
		if (incorrect_length_flag) begin
			for (int i = sedf_pkg::IDX_CYL_H; i <= sedf_pkg::IDX_SEC_L; i++) begin
				tail_d[i] = 8'h00;
			end
		end else if (!loc_relevant) begin
			for (int i = sedf_pkg::IDX_CYL_H; i <= sedf_pkg::IDX_SEC_L; i++) begin
				tail_d[i] = sedf_pkg::FILL_UNKNOWN;
			end
		end else begin
			{tail_d[sedf_pkg::IDX_CYL_H], tail_d[sedf_pkg::IDX_CYL_L]} =
				cyl_known ? cyl : sedf_pkg::CYL_UNKNOWN;
			tail_d[sedf_pkg::IDX_HEAD] = head_known ? head : sedf_pkg::FILL_UNKNOWN;
			if (sec_known) begin
				{tail_d[sedf_pkg::IDX_SEC_H], tail_d[sedf_pkg::IDX_SEC_L]} = sec;
				tail_d[sedf_pkg::IDX_SEC27] = (sec <= sedf_pkg::SEC27_MAX) ? sec[7:0]
					: sedf_pkg::FILL_UNKNOWN;
			end else begin
				tail_d[sedf_pkg::IDX_SEC27] = sedf_pkg::FILL_UNKNOWN;
				tail_d[sedf_pkg::IDX_SEC_H] = sedf_pkg::FILL_UNKNOWN;
				tail_d[sedf_pkg::IDX_SEC_L] = sedf_pkg::FILL_UNKNOWN;
			end
		end
		tail_d[sedf_pkg::IDX_RSV0] = 8'h00;
		tail_d[sedf_pkg::IDX_RSV1] = 8'h00;
	end

	generate
		for (genvar g = 0; g < sedf_pkg::TAIL_LEN; g++) begin : g_tail
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					tail_q[g] <= 8'h00;
				end else if (take) begin
					tail_q[g] <= tail_d[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rec_valid_q <= 1'b0;
			key_q       <= 4'h0;
			dir_q       <= 1'b0;
		end else if (take) begin
			rec_valid_q <= key_meaningful(rec_sense_key);
			key_q       <= rec_sense_key;
			// Software needs the direction to know which meaning bit 0 of byte 23 carries.
			dir_q       <= rec_is_write;
		end
	end
	assign rec_valid = rec_valid_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tail_byte <= 8'h00;
		end else begin
			tail_byte <= (tail_sel < 4'(sedf_pkg::TAIL_LEN)) ? tail_q[tail_sel] : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic loc_path;
	assign loc_path = take && !incorrect_length_flag && loc_relevant;

	a_reserved_zero: assert property (tail_q[10] == 8'h00 && tail_q[11] == 8'h00)
		else $error("reserved sense bytes not zero");
	a_snapshot_copy: assert property (take && rec_kind == 2'h0 |=>
		{tail_q[2], tail_q[1], tail_q[0]} == $past(dc_snapshot))
		else $error("controller snapshot not copied");
	a_rw_flags: assert property (take && rec_kind == 2'h0 |=> tail_q[3] ==
		{$past(err_overrun), $past(err_write_abort), $past(err_write_fault),
		$past(err_data_address_mark), 1'b0, $past(err_req), $past(err_ta_long), $past(err_bit0)})
		else $error("error flag byte wrong");
	a_alert_read: assert property (take && rec_kind == 2'h1 && rec_asc == 8'h5d
		&& alert_reason == 3'h0 |=> tail_q[1] == 8'h32)
		else $error("read rate reason code wrong");
	a_alert_cycles: assert property (take && rec_kind == 2'h1 && rec_asc == 8'h5d
		&& alert_reason == 3'h7 |=> tail_q[1] == 8'h50 && tail_q[3] == 8'h00)
		else $error("load cycle reason code wrong");
	a_ili_zero: assert property (take && incorrect_length_flag |=>
		{tail_q[4], tail_q[5], tail_q[6], tail_q[7], tail_q[8], tail_q[9]} == 48'h0)
		else $error("record not zero with incorrect length");
	a_cyl_unknown: assert property (loc_path && !cyl_known |=>
		tail_q[4] == 8'h0f && tail_q[5] == 8'hff)
		else $error("unknown cylinder fill wrong");
	a_head_unknown: assert property (loc_path && !head_known |=> tail_q[6] == 8'hff)
		else $error("unknown head fill wrong");
	a_sec_unknown: assert property (loc_path && !sec_known |=>
		tail_q[7] == 8'hff && tail_q[8] == 8'hff && tail_q[9] == 8'hff)
		else $error("unknown sector fill wrong");
	a_sec_big: assert property (loc_path && sec_known && sec > 16'h00fe |=>
		tail_q[7] == 8'hff ##1 tail_q[7] == 8'hff || $past(take))
		else $error("byte 27 not filled for large sector");
	a_loc_known: assert property (loc_path && cyl_known && head_known && sec_known |=>
		{tail_q[4], tail_q[5]} == $past(cyl) && tail_q[6] == $past(head)
		&& {tail_q[8], tail_q[9]} == $past(sec))
		else $error("location bytes wrong");
	a_no_relevance: assert property (take && !incorrect_length_flag && !loc_relevant |=>
		{tail_q[4], tail_q[5], tail_q[6], tail_q[7], tail_q[8], tail_q[9]} == {6{8'hff}})
		else $error("irrelevant location not filled");
	a_valid_key: assert property (take |=>
		rec_valid == ($past(rec_sense_key) inside {4'h1, 4'h3, 4'h4}))
		else $error("record valid flag wrong");
	a_key_kept: assert property (take |=> key_q == $past(rec_sense_key))
		else $error("captured sense key wrong");

	// Reason codes not covered by the two checks above.
	a_alert_write: assert property (take && rec_kind == 2'h1 && rec_asc == 8'h5d
		&& alert_reason == 3'h1 |=> tail_q[1] == 8'h4a)
		else $error("write rate reason code wrong");
	a_alert_seek: assert property (take && rec_kind == 2'h1 && rec_asc == 8'h5d
		&& alert_reason == 3'h2 |=> tail_q[1] == 8'h43)
		else $error("seek rate reason code wrong");
	a_alert_spare: assert property (take && rec_kind == 2'h1 && rec_asc == 8'h5d
		&& alert_reason == 3'h3 |=> tail_q[1] == 8'h14)
		else $error("spare sector reason code wrong");
	a_alert_spinup: assert property (take && rec_kind == 2'h1 && rec_asc == 8'h5d
		&& alert_reason == 3'h4 |=> tail_q[1] == 8'h56)
		else $error("spin-up time reason code wrong");
	a_alert_retry: assert property (take && rec_kind == 2'h1 && rec_asc == 8'h5d
		&& alert_reason == 3'h5 |=> tail_q[1] == 8'h5b)
		else $error("spin-up retry reason code wrong");
	a_alert_hours: assert property (take && rec_kind == 2'h1 && rec_asc == 8'h5d
		&& alert_reason == 3'h6 |=> tail_q[1] == 8'h00)
		else $error("power-on hour reason code wrong");

	// Bytes 20 to 23 stay zero unless a read/write error or a 5Dh alert is recorded.
	a_alert_other_asc: assert property (take && rec_kind == 2'h1 && rec_asc != 8'h5d |=>
		{tail_q[3], tail_q[2], tail_q[1], tail_q[0]} == 32'h0)
		else $error("alert without 5Dh left error bytes set");
	a_other_kind: assert property (take && rec_kind[1] |=>
		{tail_q[3], tail_q[2], tail_q[1], tail_q[0]} == 32'h0)
		else $error("other event left error bytes set");

	// Bits 1 and 0 of byte 23 and the operation direction travel on their own.
	a_ta_long: assert property (take && rec_kind == 2'h0 |=>
		tail_q[3][1] == $past(err_ta_long))
		else $error("long asperity flag wrong");
	a_bit0_pass: assert property (take && rec_kind == 2'h0 |=>
		tail_q[3][0] == $past(err_bit0) && dir_q == $past(rec_is_write))
		else $error("bit 0 or direction wrong");

	// Known location fields one at a time, so that a fault in one is not hidden by another; then the reserved byte port.
	a_cyl_known: assert property (loc_path && cyl_known |=>
		{tail_q[4], tail_q[5]} == $past(cyl))
		else $error("known cylinder wrong");
	a_head_known: assert property (loc_path && head_known |=>
		tail_q[6] == $past(head))
		else $error("known head wrong");
	a_sec27_small: assert property (loc_path && sec_known && sec < 16'h00ff |=>
		tail_q[7] == $past(sec[7:0]))
		else $error("byte 27 not the sector number");
	a_tail_byte: assert property (tail_sel == 4'ha |=> tail_byte == 8'h00)
		else $error("reserved byte port not zero");

	// A refused capture leaves the record alone; a capture wins over a clear.
	a_refused: assert property (!take |=>
		$stable(key_q) && $stable(tail_q[3]) && $stable(tail_q[7]))
		else $error("record changed without a capture");
	a_set_wins: assert property (take && wr_pend_q && wr_addr_q == sedf_pkg::ADDR_IRQ_STAT |=>
		irq_stat_q[0])
		else $error("clear beat a new capture");
	a_stat_clear: assert property (!take && wr_pend_q && wr_addr_q == sedf_pkg::ADDR_IRQ_STAT |=>
		(irq_stat_q & $past(hwdata[1:0])) == 2'h0)
		else $error("status bit not cleared");
endmodule

`default_nettype wire

// ---- rtl/sedf_pkg.sv ----
/*
 * Constants shared by the sense error detail formatter: register map,
 * field positions, fill values and the failure-prediction reason codes.
 * Assumes a 32-bit AHB-Lite register bus and byte-wide sense data.
 */
package sedf_pkg;
	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_TAIL_A   = 8'h0c;
	localparam logic [7:0] ADDR_TAIL_B   = 8'h10;
	localparam logic [7:0] ADDR_TAIL_C   = 8'h14;
	localparam logic [7:0] ADDR_INFO     = 8'h18;

	// Control and interrupt field positions.
	localparam int CTRL_EN_BIT    = 0;
	localparam int IRQ_CAP_BIT    = 0;
	localparam int IRQ_ALERT_BIT  = 1;
	localparam int IRQ_W          = 2;

	// Reset values.
	localparam logic       CTRL_EN_RST  = 1'b1;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;

	// Tail geometry: bytes 20 to 31 of the sense block.
	localparam int TAIL_FIRST = 20;
	localparam int TAIL_LEN   = 12;
	localparam int IDX_VU0    = 0;
	localparam int IDX_VU1    = 1;
	localparam int IDX_VU3    = 3;
	localparam int IDX_CYL_H  = 4;
	localparam int IDX_CYL_L  = 5;
	localparam int IDX_HEAD   = 6;
	localparam int IDX_SEC27  = 7;
	localparam int IDX_SEC_H  = 8;
	localparam int IDX_SEC_L  = 9;
	localparam int IDX_RSV0   = 10;
	localparam int IDX_RSV1   = 11;

	// Fill values.
	localparam logic [7:0]  FILL_UNKNOWN   = 8'hff;
	localparam logic [15:0] CYL_UNKNOWN    = 16'h0fff;
	localparam logic [15:0] SEC27_MAX      = 16'h00fe;

	// Sense keys for which the location record is meaningful.
	localparam logic [3:0] KEY_RECOVERED = 4'h1;
	localparam logic [3:0] KEY_MEDIUM    = 4'h3;
	localparam logic [3:0] KEY_HARDWARE  = 4'h4;

	// Failure-prediction alert reasons and their codes.
	typedef enum logic [2:0] {
		SEDF_RSN_READ_RATE, SEDF_RSN_WRITE_RATE, SEDF_RSN_SEEK_RATE, SEDF_RSN_SPARE,
		SEDF_RSN_SPINUP_TIME, SEDF_RSN_SPINUP_RETRY, SEDF_RSN_POWER_HOURS, SEDF_RSN_LOAD_CYCLES
	} sedf_reason_t;
	localparam logic [7:0] CODE_READ_RATE    = 8'h32;
	localparam logic [7:0] CODE_WRITE_RATE   = 8'h4a;
	localparam logic [7:0] CODE_SEEK_RATE    = 8'h43;
	localparam logic [7:0] CODE_SPARE        = 8'h14;
	localparam logic [7:0] CODE_SPINUP_TIME  = 8'h56;
	localparam logic [7:0] CODE_SPINUP_RETRY = 8'h5b;
	localparam logic [7:0] CODE_POWER_HOURS  = 8'h00;
	localparam logic [7:0] CODE_LOAD_CYCLES  = 8'h50;

	// Kind of event being recorded.
	typedef enum logic [1:0] {SEDF_KIND_RW, SEDF_KIND_ALERT, SEDF_KIND_OTHER} sedf_kind_t;
endpackage

// ---- test/sedf_sense_reader.sv ----
/*
 * Reader model of the initiator side: walks the tail byte port through
 * sense bytes 20 to 31 after a start pulse and returns them in one word.
 * Assumes tail_byte answers one edge after tail_sel, as the device does.
 */
`timescale 1ns/1ns
`default_nettype none

module sedf_sense_reader (
	input  wire logic        hclk,      // Clock.
	input  wire logic        hresetn,   // Reset, active low.
	input  wire logic        start,     // Pulse: fetch the tail.
	input  wire logic [7:0]  tail_byte, // Byte from the device.
	input  wire logic        rec_valid, // Location record meaningful.
	output logic      [3:0]  tail_sel,  // Byte index asked for.
	output logic      [95:0] sense_q,   // Bytes 20 to 31, byte 20 lowest.
	output logic             loc_ok_q,  // Location record may be used.
	output logic             done_q     // Pulse: fetch complete.
);
	logic [4:0] cnt_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 5'h1f;
			tail_sel <= 4'h0;
			sense_q <= '0;
			loc_ok_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				cnt_q <= 5'h00;
				tail_sel <= 4'h0;
			end else if (cnt_q <= 5'd12) begin
				// The byte seen now was asked for two edges ago.
				tail_sel <= cnt_q[3:0] + 4'h1;
				if (cnt_q != 5'd0)
					sense_q[8 * (int'(cnt_q) - 1) +: 8] <= tail_byte;
				if (cnt_q == 5'd12) begin
					done_q <= 1'b1;
					loc_ok_q <= rec_valid;
					cnt_q <= 5'h1f;
				end else
					cnt_q <= cnt_q + 5'h01;
			end
		end
	end
endmodule

`default_nettype wire

// ---- test/sedf_top_bench.sv ----
/*
 * Self-checking bench of the sense error detail formatter: random and corner
 * error records, tail fetched by the reader model and over AHB-Lite.
 * Assumes one 25 MHz clock and a slave that may stretch no phase forever.
 */
`timescale 1ns/1ns
`default_nettype none

module sedf_top_bench;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, start = 1'b0;
	logic        rec_capture = 1'b0, rec_is_write = 1'b0, incorrect_length_flag = 1'b0;
	logic        loc_relevant = 1'b0, cyl_known = 1'b0, head_known = 1'b0, sec_known = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, rd, r = 32'd44524;
	logic [1:0]  htrans = '0, rec_kind = '0;
	logic [2:0]  hsize = 3'h2, alert_reason = '0;
	logic [3:0]  rec_sense_key = '0, tail_sel;
	logic [7:0]  rec_asc = '0, head = '0, fl = '0, tail_byte;
	logic [23:0] dc_snapshot = '0;
	logic [15:0] cyl = '0, sec = '0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, irq, rec_valid, loc_ok_q, done_q, exp_kv = 1'b0;
	logic [95:0] sense_q, exp_q = '0;
	int          err_count = 0, compares = 0, cycles = 0;

	sedf_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .irq, .rec_capture, .rec_kind, .rec_is_write,
		.rec_sense_key, .rec_asc, .dc_snapshot, .err_overrun(fl[7]), .err_write_abort(fl[6]),
		.err_write_fault(fl[5]), .err_data_address_mark(fl[4]), .err_req(fl[2]),
		.err_ta_long(fl[1]), .err_bit0(fl[0]), .alert_reason, .incorrect_length_flag,
		.loc_relevant, .cyl_known, .cyl, .head_known, .head, .sec_known, .sec, .tail_sel,
		.tail_byte, .rec_valid);
	sedf_sense_reader reader (.hclk, .hresetn, .start, .tail_byte, .rec_valid, .tail_sel,
		.sense_q, .loc_ok_q, .done_q);

	always #20 hclk = ~hclk;

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction

	function automatic logic [95:0] exp_tail();
		logic [7:0]  b [12] = '{default: 8'h00};
		logic [7:0]  codes [8] = '{8'h32, 8'h4a, 8'h43, 8'h14, 8'h56, 8'h5b, 8'h00, 8'h50};
		logic [95:0] t;
		if (rec_kind == 2'h0) begin
			{b[2], b[1], b[0]} = dc_snapshot;
			b[3] = {fl[7:4], 1'b0, fl[2:0]};
		end else if (rec_kind == 2'h1 && rec_asc == 8'h5d)
			b[1] = codes[alert_reason];
		if (!incorrect_length_flag && !loc_relevant) begin
			for (int i = 4; i < 10; i++)
				b[i] = 8'hff;
		end else if (!incorrect_length_flag) begin
			{b[4], b[5]} = cyl_known ? cyl : 16'h0fff;
			b[6] = head_known ? head : 8'hff;
			{b[8], b[9]} = sec_known ? sec : 16'hffff;
			b[7] = (sec_known && sec <= 16'd254) ? sec[7:0] : 8'hff;
		end
		for (int i = 0; i < 12; i++)
			t[8 * i +: 8] = b[i];
		return t;
	endfunction

	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Compares %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk(hresp, 1'b0);
	endtask

	task automatic irq_is(input logic e);
		@(negedge hclk);
		chk(irq, e);
		@(posedge hclk);
	endtask

	task automatic rand_rec(input int i);
		r = xs(r);
		dc_snapshot <= r[23:0];
		fl <= r[31:24];
		r = xs(r);
		cyl <= r[15:0];
		head <= r[23:16];
		rec_sense_key <= r[27:24];
		rec_kind <= (i < 8) ? 2'h1 : r[29:28];
		rec_is_write <= r[30];
		r = xs(r);
		sec <= r[3] ? 16'd250 + 16'(r[6:4]) : r[31:16];
		alert_reason <= (i < 8) ? i[2:0] : r[9:7];
		rec_asc <= (i < 8 || r[10]) ? 8'h5d : r[18:11];
		incorrect_length_flag <= r[19] & r[20];
		loc_relevant <= r[21] | r[22];
		cyl_known <= r[23] | r[24];
		head_known <= r[25] | r[26];
		sec_known <= r[27] | r[28];
	endtask

	task automatic cap_and_fetch(input logic en);
		rec_capture <= 1'b1;
		@(posedge hclk);
		rec_capture <= 1'b0;
		if (en) begin
			exp_q = exp_tail();
			exp_kv = rec_sense_key inside {4'h1, 4'h3, 4'h4};
		end
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
		while (done_q !== 1'b1) @(posedge hclk);
		chk(sense_q, exp_q);
		chk(loc_ok_q, exp_kv);
	endtask

	initial begin
		logic [7:0]  ra [4] = '{8'h00, 8'h04, 8'h08, 8'h1c};
		logic [31:0] rv [4] = '{32'h1, 32'h0, 32'h0, 32'h0};
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		for (int i = 0; i < 40; i++) begin
			rand_rec(i);
			cap_and_fetch(1'b1);
			ahb(1'b0, sedf_pkg::ADDR_TAIL_A, 32'h0);
			chk(rd, exp_q[31:0]);
			ahb(1'b0, sedf_pkg::ADDR_TAIL_B, 32'h0);
			chk(rd, exp_q[63:32]);
			ahb(1'b0, sedf_pkg::ADDR_TAIL_C, 32'h0);
			chk(rd, exp_q[95:64]);
			ahb(1'b0, sedf_pkg::ADDR_INFO, 32'h0);
			chk(rd, {26'h0, rec_is_write, exp_kv, rec_sense_key});
		end
		// Events raise sticky bits; masking and write-one-to-clear act alone.
		ahb(1'b1, sedf_pkg::ADDR_IRQ_MASK, 32'h3);
		ahb(1'b1, sedf_pkg::ADDR_IRQ_STAT, 32'h3);
		irq_is(1'b0);
		rand_rec(2);
		cap_and_fetch(1'b1);
		irq_is(1'b1);
		ahb(1'b0, sedf_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h3);
		ahb(1'b1, sedf_pkg::ADDR_IRQ_MASK, 32'h0);
		irq_is(1'b0);
		ahb(1'b1, sedf_pkg::ADDR_IRQ_STAT, 32'h1);
		ahb(1'b0, sedf_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h2);
		ahb(1'b1, sedf_pkg::ADDR_IRQ_MASK, 32'h2);
		irq_is(1'b1);
		ahb(1'b1, sedf_pkg::ADDR_IRQ_STAT, 32'h2);
		irq_is(1'b0);
		// A capture in the data phase of a clear keeps its status bit set.
		fork
			ahb(1'b1, sedf_pkg::ADDR_IRQ_STAT, 32'h1);
			begin
				@(posedge hclk);
				rec_capture <= 1'b1;
				@(posedge hclk);
				rec_capture <= 1'b0;
			end
		join
		ahb(1'b0, sedf_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h3);
		ahb(1'b1, sedf_pkg::ADDR_IRQ_STAT, 32'h3);
		// With capture disabled the previous tail must survive a new record.
		ahb(1'b1, sedf_pkg::ADDR_CTRL, 32'h0);
		ahb(1'b0, sedf_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		rand_rec(9);
		cap_and_fetch(1'b0);
		ahb(1'b0, sedf_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h0);
		tally_and_finish();
	end
endmodule

`default_nettype wire
